// *** hw/dual_fifo_regs.svh ***
// Contract
// - pulse both full resets together first
// - fifo1 full reset: four A, B edges
// - fifo2 full reset: four A, C edges
// - full reset inputs asynchronous to clocks
// - full reset: pointers home, flags cleared
// - full reset sets mailbox full flag high
// - space flag high two write cycles later
// - fifo1 reset rise captures select inputs
// - fifo2 rise clears offsets; joint captures
// - port C mail select high during reset
// - fifo1 partial clear: four A, B edges
// - fifo2 partial clear: four A, C edges
// - replay select low during partial clear
// - partial clear inputs asynchronous to clocks
// - partial clear: pointers home, flags cleared
// - partial clear sets mailbox full high
// - partial clear: space flag after two
// - partial clear keeps offsets, method, mode
// - fifo1 replay: read pointer to start
// - fifo2 replay: read pointer to start
// - shared pin; replay select picks function
// - byte order high big, low little
// - next edge after reset picks timing mode
`ifndef DUAL_FIFO_REGS_SVH
`define DUAL_FIFO_REGS_SVH
`define FIFO_DEPTH_LOG2     4
`define FIFO_WIDTH          36
`define RESET_MIN_EDGES     4
`define SPACE_DELAY_CYCLES  2
`define OFFSET_WIDTH        13
`define OFFSET_RESET        13'h0000
`endif

// *** hw/dual_fifo_pkg.sv ***
package dual_fifo_pkg;
  typedef enum logic [1:0] {PHASE_RESET, PHASE_WAIT, PHASE_RUN} phase_e;
  typedef struct packed {
    logic [2:0] offsetSelect;
    logic       bigEndian;
    logic       methodValid;
  } config_s;
endpackage

// *** hw/dual_fifo_ctrl_if.sv ***
`timescale 1ns/1ps
interface dual_fifo_ctrl_if;
  logic fifo1_full_reset_n;
  logic fifo2_full_reset_n;
  logic fifo1_partial_clear_n;
  logic fifo2_partial_clear_n;
  logic replay_select;
  logic byte_order_timing_select;
  logic offset_select_0;
  logic offset_select_1;
  logic offset_select_2;
  logic port_c_mail_select;
  logic fifo1_space_flag;
  logic fifo2_space_flag;
  logic fifo1_data_flag;
  logic fifo2_data_flag;
  logic fifo1_near_empty_n;
  logic fifo2_near_empty_n;
  logic fifo1_near_full_n;
  logic fifo2_near_full_n;
  logic mail1_full_n;
  logic mail2_full_n;
  modport device (
    input  fifo1_full_reset_n, fifo2_full_reset_n, fifo1_partial_clear_n,
    input  fifo2_partial_clear_n, replay_select, byte_order_timing_select,
    input  offset_select_0, offset_select_1, offset_select_2, port_c_mail_select,
    output fifo1_space_flag, fifo2_space_flag, fifo1_data_flag, fifo2_data_flag,
    output fifo1_near_empty_n, fifo2_near_empty_n, fifo1_near_full_n,
    output fifo2_near_full_n, mail1_full_n, mail2_full_n
  );
  modport controller (
    output fifo1_full_reset_n, fifo2_full_reset_n, fifo1_partial_clear_n,
    output fifo2_partial_clear_n, replay_select, byte_order_timing_select,
    output offset_select_0, offset_select_1, offset_select_2, port_c_mail_select,
    input  fifo1_space_flag, fifo2_space_flag, fifo1_data_flag, fifo2_data_flag,
    input  fifo1_near_empty_n, fifo2_near_empty_n, fifo1_near_full_n,
    input  fifo2_near_full_n, mail1_full_n, mail2_full_n
  );
endinterface

// *** hw/dual_fifo_device.sv ***
`timescale 1ns/1ps
`include "dual_fifo_regs.svh"
module dual_fifo_device (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // link
  dual_fifo_ctrl_if.device                link,
  // user side: data path
  input  wire logic                       fifo1Write,
  input  wire logic [`FIFO_WIDTH-1:0]     fifo1WriteData,
  input  wire logic                       fifo1Read,
  output logic [`FIFO_WIDTH-1:0]          fifo1ReadData,
  input  wire logic                       fifo2Write,
  input  wire logic [`FIFO_WIDTH-1:0]     fifo2WriteData,
  input  wire logic                       fifo2Read,
  output logic [`FIFO_WIDTH-1:0]          fifo2ReadData,
  input  wire logic                       mail1Write,
  input  wire logic                       mail1Read,
  input  wire logic                       mail2Write,
  input  wire logic                       mail2Read,
  // user side: captured configuration
  output logic                            bigEndian,
  output logic                            fallThrough,
  output logic [2:0]                      offsetMethod,
  output logic [`OFFSET_WIDTH-1:0]        fifo2EmptyOffset,
  output logic [`OFFSET_WIDTH-1:0]        fifo2FullOffset
);
  localparam int AW = `FIFO_DEPTH_LOG2;
  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    logic [AW:0]                    wp;
    logic [AW:0]                    rp;
    logic [1:0]                     delay;
    dual_fifo_pkg::phase_e          phase;
    logic                           mailFull;
    logic                           holdLow;
    logic [`FIFO_WIDTH-1:0]         rdata;
  } fifo_s;

  typedef struct packed {
    logic [4:0]                     sync1;
    logic [4:0]                     sync2;
    logic [4:0]                     sync3;
    logic [3:0]                     selA;
    logic [3:0]                     selB;
    fifo_s                          f1;
    fifo_s                          f2;
    dual_fifo_pkg::config_s         cfg;
    logic                           fallThrough;
    logic                           jointRise;
    logic [`OFFSET_WIDTH-1:0]       emptyOffset2;
    logic [`OFFSET_WIDTH-1:0]       fullOffset2;
  } state_s;

  state_s st;
  state_s next_st;
  logic [`FIFO_WIDTH-1:0] mem1 [DEPTH];
  logic [`FIFO_WIDTH-1:0] mem2 [DEPTH];

  // raw order: full1, full2, partial1, partial2, replay select
  logic [4:0] rawIn;
  logic [4:0] syn;
  assign rawIn = {link.fifo1_full_reset_n, link.fifo2_full_reset_n,
                  link.fifo1_partial_clear_n, link.fifo2_partial_clear_n,
                  link.replay_select};
  assign syn = st.sync2;

  function automatic logic [AW:0] countOf(input logic [AW:0] w, input logic [AW:0] r);
    countOf = w - r;
  endfunction

  // a write lands only while running with no reset or replay held and a slot free
  function automatic logic acceptWrite(input fifo_s f, input logic fullN, input logic pinN,
                                       input logic wr);
    acceptWrite = wr && fullN && pinN && f.phase == dual_fifo_pkg::PHASE_RUN &&
                  countOf(f.wp, f.rp) != (AW+1)'(DEPTH);
  endfunction

  logic wr1Ok;
  logic wr2Ok;
  logic rise1;
  logic rise2;
  assign wr1Ok = acceptWrite(st.f1, syn[4], syn[2], fifo1Write);
  assign wr2Ok = acceptWrite(st.f2, syn[3], syn[1], fifo2Write);
  // edges taken one stage past the synchroniser, so its first flop feeds nothing else
  assign rise1 = st.sync2[4] && !st.sync3[4];
  assign rise2 = st.sync2[3] && !st.sync3[3];

  // one fifo step: full reset, partial clear or replay, then normal traffic
  function automatic fifo_s stepFifo(input fifo_s f, input logic fullN, input logic pinN,
                                     input logic rtSel, input logic wr, input logic rd,
                                     input logic [`FIFO_WIDTH-1:0] rdWord,
                                     input logic mw, input logic mr);
    fifo_s n;
    logic  clr;
    n = f;
    clr = !fullN || (!pinN && !rtSel);
    if (clr)
    begin
      n.wp = '0;
      n.rp = '0;
      n.phase = dual_fifo_pkg::PHASE_RESET;
      n.delay = '0;
      n.mailFull = 1'b0;
    end
    else if (!pinN && rtSel)
    begin
      n.rp = '0;
      n.holdLow = 1'b1;
    end
    else
    begin
      n.holdLow = 1'b0;
      unique case (f.phase)
        dual_fifo_pkg::PHASE_RESET:
          n.phase = dual_fifo_pkg::PHASE_WAIT;
        dual_fifo_pkg::PHASE_WAIT:
        begin
          n.delay = f.delay + 2'b01;
          if (f.delay == 2'(`SPACE_DELAY_CYCLES - 1))
            n.phase = dual_fifo_pkg::PHASE_RUN;
        end
        dual_fifo_pkg::PHASE_RUN:
        begin
          if (acceptWrite(f, fullN, pinN, wr))
            n.wp = f.wp + 1'b1;
          if (rd && f.wp != f.rp)
          begin
            n.rp = f.rp + 1'b1;
            n.rdata = rdWord;
          end
          if (mw)
            n.mailFull = 1'b1;
          else if (mr)
            n.mailFull = 1'b0;
        end
      endcase
    end
    return n;
  endfunction

  always_comb
  begin
    next_st = st;
    next_st.sync1 = rawIn;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    next_st.f1 = stepFifo(st.f1, syn[4], syn[2], syn[0], fifo1Write, fifo1Read,
                          mem1[st.f1.rp[AW-1:0]], mail1Write, mail1Read);
    next_st.f2 = stepFifo(st.f2, syn[3], syn[1], syn[0], fifo2Write, fifo2Read,
                          mem2[st.f2.rp[AW-1:0]], mail2Write, mail2Read);
    // select pins ride the same two stages as the resets, so both line up at the edge
    next_st.selA = {link.byte_order_timing_select, link.offset_select_2,
                    link.offset_select_1, link.offset_select_0};
    next_st.selB = st.selA;
    next_st.jointRise = 1'b0;
    if (rise1)
    begin
      next_st.cfg.offsetSelect = st.selB[2:0];
      next_st.cfg.bigEndian = st.selB[3];
      next_st.cfg.methodValid = 1'b1;
      next_st.jointRise = 1'b1;
    end
    if (rise2)
    begin
      next_st.emptyOffset2 = `OFFSET_RESET;
      next_st.fullOffset2 = `OFFSET_RESET;
      if (!rise1)
        next_st.cfg = st.cfg;
    end
    // timing mode after release; partial clear leaves it
    if (st.jointRise)
      next_st.fallThrough = !st.selB[3];
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
      st.sync1 <= 5'h1f;
      st.sync2 <= 5'h1f;
      st.sync3 <= 5'h1f;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (wr1Ok)
      mem1[st.f1.wp[AW-1:0]] <= fifo1WriteData;
    if (wr2Ok)
      mem2[st.f2.wp[AW-1:0]] <= fifo2WriteData;
  end

  // flags are registered each cycle from state
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      link.fifo1_space_flag   <= 1'b0;
      link.fifo2_space_flag   <= 1'b0;
      link.fifo1_data_flag    <= 1'b0;
      link.fifo2_data_flag    <= 1'b0;
      link.fifo1_near_empty_n <= 1'b0;
      link.fifo2_near_empty_n <= 1'b0;
      link.fifo1_near_full_n  <= 1'b1;
      link.fifo2_near_full_n  <= 1'b1;
      link.mail1_full_n       <= 1'b1;
      link.mail2_full_n       <= 1'b1;
    end
    else
    begin
      link.fifo1_space_flag   <= next_st.f1.phase == dual_fifo_pkg::PHASE_RUN &&
                                 countOf(next_st.f1.wp, next_st.f1.rp) != (AW+1)'(DEPTH);
      link.fifo2_space_flag   <= next_st.f2.phase == dual_fifo_pkg::PHASE_RUN &&
                                 countOf(next_st.f2.wp, next_st.f2.rp) != (AW+1)'(DEPTH);
      link.fifo1_data_flag    <= next_st.f1.wp != next_st.f1.rp;
      link.fifo2_data_flag    <= next_st.f2.wp != next_st.f2.rp;
      link.fifo1_near_empty_n <= countOf(next_st.f1.wp, next_st.f1.rp) > (AW+1)'(1);
      link.fifo2_near_empty_n <= countOf(next_st.f2.wp, next_st.f2.rp) > (AW+1)'(1);
      link.fifo1_near_full_n  <= countOf(next_st.f1.wp, next_st.f1.rp) < (AW+1)'(DEPTH-1);
      link.fifo2_near_full_n  <= countOf(next_st.f2.wp, next_st.f2.rp) < (AW+1)'(DEPTH-1);
      link.mail1_full_n       <= !next_st.f1.mailFull;
      link.mail2_full_n       <= !next_st.f2.mailFull;
    end
  end

  assign fifo1ReadData    = st.f1.rdata;
  assign fifo2ReadData    = st.f2.rdata;
  assign bigEndian        = st.cfg.bigEndian;
  assign fallThrough      = st.fallThrough;
  assign offsetMethod     = st.cfg.offsetSelect;
  assign fifo2EmptyOffset = st.emptyOffset2;
  assign fifo2FullOffset  = st.fullOffset2;
endmodule

// *** hw/dual_fifo_controller.sv ***
`timescale 1ns/1ps
`include "dual_fifo_regs.svh"
module dual_fifo_controller (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // link
  dual_fifo_ctrl_if.controller link,
  // user side requests, one-cycle pulses, then configuration levels
  input  wire logic        startFullReset,
  input  wire logic        startClear1,
  input  wire logic        startClear2,
  input  wire logic        startReplay1,
  input  wire logic        startReplay2,
  input  wire logic        cfgBigEndian,
  input  wire logic        cfgFallThrough,
  input  wire logic [2:0]  cfgOffsetSelect,
  // user side status
  output logic             busy,
  output logic             deviceReady
);
  typedef enum logic [2:0] {IDLE, FULL, CLR1, CLR2, RPL1, RPL2, MODE, WAITUP} op_e;
  typedef struct packed {
    op_e        op;
    logic [3:0] cnt;
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic       ready;
  } state_s;

  state_s st;
  state_s next_st;
  logic   holdDone;
  // four extra margin edges cover the synchroniser stages on the far side
  assign holdDone = st.cnt == 4'(`RESET_MIN_EDGES + 3);

  always_comb
  begin
    next_st = st;
    next_st.syncA = {st.syncA[0], link.fifo1_space_flag};
    next_st.syncB = {st.syncB[0], link.fifo2_space_flag};
    next_st.cnt = st.cnt + 4'h1;
    unique case (st.op)
      IDLE:
      begin
        next_st.cnt = '0;
        if (startFullReset)
        begin
          next_st.op = FULL;
          next_st.ready = 1'b0;
        end
        else if (startClear1)
          next_st.op = CLR1;
        else if (startClear2)
          next_st.op = CLR2;
        else if (startReplay1)
          next_st.op = RPL1;
        else if (startReplay2)
          next_st.op = RPL2;
      end
      FULL, CLR1, CLR2, RPL1, RPL2:
        if (holdDone)
        begin
          next_st.op = (st.op == FULL) ? MODE : IDLE;
          next_st.cnt = '0;
        end
      MODE:
        if (holdDone)
          next_st.op = WAITUP;
      WAITUP:
        if (st.syncA[1] && st.syncB[1])
        begin
          next_st.op = IDLE;
          next_st.ready = 1'b1;
        end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      link.fifo1_full_reset_n       <= 1'b1;
      link.fifo2_full_reset_n       <= 1'b1;
      link.fifo1_partial_clear_n    <= 1'b1;
      link.fifo2_partial_clear_n    <= 1'b1;
      link.replay_select            <= 1'b0;
      link.byte_order_timing_select <= 1'b0;
      link.offset_select_0          <= 1'b0;
      link.offset_select_1          <= 1'b0;
      link.offset_select_2          <= 1'b0;
      link.port_c_mail_select       <= 1'b1;
      busy                          <= 1'b0;
      deviceReady                   <= 1'b0;
    end
    else
    begin
      link.fifo1_full_reset_n    <= next_st.op != FULL;
      link.fifo2_full_reset_n    <= next_st.op != FULL;
      // shared pin for clear and replay
      link.fifo1_partial_clear_n <= !(next_st.op == CLR1 || next_st.op == RPL1);
      link.fifo2_partial_clear_n <= !(next_st.op == CLR2 || next_st.op == RPL2);
      link.replay_select         <= next_st.op == RPL1 || next_st.op == RPL2;
      // byte order stays one cycle past the reset rise, then the mode level follows
      link.byte_order_timing_select <= (st.op == MODE || st.op == WAITUP) ?
                                       !cfgFallThrough : cfgBigEndian;
      link.offset_select_0       <= cfgOffsetSelect[0];
      link.offset_select_1       <= cfgOffsetSelect[1];
      link.offset_select_2       <= cfgOffsetSelect[2];
      link.port_c_mail_select    <= 1'b1;
      busy                       <= next_st.op != IDLE;
      deviceReady                <= next_st.ready;
    end
  end
endmodule

// *** verif/dual_fifo_reset_retransmit_assertions.sv ***
`timescale 1ns/1ps
module dual_fifo_reset_retransmit_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // controller driven
  input wire logic fifo1_full_reset_n,
  input wire logic fifo2_full_reset_n,
  input wire logic fifo1_partial_clear_n,
  input wire logic fifo2_partial_clear_n,
  input wire logic replay_select,
  input wire logic port_c_mail_select,
  // device driven
  input wire logic fifo1_space_flag,
  input wire logic fifo2_space_flag,
  input wire logic fifo1_data_flag,
  input wire logic fifo2_data_flag,
  input wire logic fifo1_near_empty_n,
  input wire logic fifo2_near_empty_n,
  input wire logic fifo1_near_full_n,
  input wire logic fifo2_near_full_n,
  input wire logic mail1_full_n,
  input wire logic mail2_full_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_full_joint_pulse: assert property ($fell(fifo1_full_reset_n) |-> $fell(fifo2_full_reset_n))
    else $error("full resets not pulsed together");
  a_full_reset_width: assert property ($fell(fifo1_full_reset_n) |-> !fifo1_full_reset_n[*4])
    else $error("full reset shorter than four edges");
  // sync delay plus forcing lands well inside the eight-cycle pulse
  a_full_forces_flags: assert property ($fell(fifo2_full_reset_n) |-> ##5 (!fifo2_space_flag
    && !fifo2_data_flag && !fifo2_near_empty_n && fifo2_near_full_n && mail2_full_n))
    else $error("full reset did not force fifo2 flags");
  a_clear_forces_flags: assert property ($fell(fifo1_partial_clear_n) && !replay_select |-> ##5
    (!fifo1_space_flag && !fifo1_data_flag && !fifo1_near_empty_n && fifo1_near_full_n
    && mail1_full_n))
    else $error("partial clear did not force fifo1 flags");
  a_space_after_clear: assert property ($rose(fifo1_partial_clear_n) && !$past(replay_select)
    |-> !fifo1_space_flag[*2] ##[1:8] fifo1_space_flag)
    else $error("space flag timing after partial clear");
  a_space_after_full: assert property ($rose(fifo2_full_reset_n)
    |-> !fifo2_space_flag[*2] ##[1:12] fifo2_space_flag)
    else $error("space flag timing after full reset");
  a_clear_pin_width: assert property ($fell(fifo2_partial_clear_n) |-> !fifo2_partial_clear_n[*4])
    else $error("shared pin pulse shorter than four edges");
  a_select_held: assert property ((!fifo1_partial_clear_n && !$past(fifo1_partial_clear_n))
    || (!fifo2_partial_clear_n && !$past(fifo2_partial_clear_n)) |-> $stable(replay_select))
    else $error("replay select moved during pulse");
  a_replay_keeps_space: assert property ($fell(fifo1_partial_clear_n) && replay_select
    && fifo1_space_flag |-> fifo1_space_flag[*8])
    else $error("replay acted as a partial clear");
  a_mail_c_high: assert property (port_c_mail_select)
    else $error("port c mail select low");
endmodule

// *** verif/dual_fifo_reset_retransmit_tb_top.sv ***
`timescale 1ns/1ps
`include "dual_fifo_regs.svh"
module dual_fifo_reset_retransmit_tb_top;
  logic clk_sys, reset, busy, deviceReady, bigEndian, fallThrough;
  logic startFullReset, startClear1, startClear2, startReplay1, startReplay2;
  logic cfgBigEndian, cfgFallThrough;
  logic [2:0] cfgOffsetSelect, offsetMethod;
  logic fifo1Write, fifo1Read, fifo2Write, fifo2Read, mail1Write, mail2Write;
  logic [`FIFO_WIDTH-1:0] fifo1WriteData, fifo2WriteData, fifo1ReadData, fifo2ReadData;
  logic [`OFFSET_WIDTH-1:0] fifo2EmptyOffset, fifo2FullOffset;
  int mismatches, n_compared;

  dual_fifo_ctrl_if link();
  dual_fifo_device u_dual_fifo_device (.clk_sys(clk_sys), .reset(reset), .link(link),
    .fifo1Write(fifo1Write), .fifo1WriteData(fifo1WriteData), .fifo1Read(fifo1Read),
    .fifo1ReadData(fifo1ReadData), .fifo2Write(fifo2Write), .fifo2WriteData(fifo2WriteData),
    .fifo2Read(fifo2Read), .fifo2ReadData(fifo2ReadData), .mail1Write(mail1Write),
    .mail1Read(1'b0), .mail2Write(mail2Write), .mail2Read(1'b0), .bigEndian(bigEndian),
    .fallThrough(fallThrough), .offsetMethod(offsetMethod),
    .fifo2EmptyOffset(fifo2EmptyOffset), .fifo2FullOffset(fifo2FullOffset));
  dual_fifo_controller u_dual_fifo_controller (.clk_sys(clk_sys), .reset(reset), .link(link),
    .startFullReset(startFullReset), .startClear1(startClear1), .startClear2(startClear2),
    .startReplay1(startReplay1), .startReplay2(startReplay2), .cfgBigEndian(cfgBigEndian),
    .cfgFallThrough(cfgFallThrough), .cfgOffsetSelect(cfgOffsetSelect), .busy(busy),
    .deviceReady(deviceReady));
  dual_fifo_reset_retransmit_assertions u_dual_fifo_reset_retransmit_assertions (
    .clk_sys(clk_sys), .reset(reset), .fifo1_full_reset_n(link.fifo1_full_reset_n),
    .fifo2_full_reset_n(link.fifo2_full_reset_n),
    .fifo1_partial_clear_n(link.fifo1_partial_clear_n),
    .fifo2_partial_clear_n(link.fifo2_partial_clear_n), .replay_select(link.replay_select),
    .port_c_mail_select(link.port_c_mail_select), .fifo1_space_flag(link.fifo1_space_flag),
    .fifo2_space_flag(link.fifo2_space_flag), .fifo1_data_flag(link.fifo1_data_flag),
    .fifo2_data_flag(link.fifo2_data_flag), .fifo1_near_empty_n(link.fifo1_near_empty_n),
    .fifo2_near_empty_n(link.fifo2_near_empty_n), .fifo1_near_full_n(link.fifo1_near_full_n),
    .fifo2_near_full_n(link.fifo2_near_full_n), .mail1_full_n(link.mail1_full_n),
    .mail2_full_n(link.mail2_full_n));

  always #20 clk_sys = ~clk_sys;

  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    n_compared++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // 0 full reset, 1/2 clear, 3/4 replay; settle leaves room for the flag resync
  task automatic run(input int k);
    int i;
    i = 0;
    startFullReset = (k == 0);
    startClear1 = (k == 1);
    startClear2 = (k == 2);
    startReplay1 = (k == 3);
    startReplay2 = (k == 4);
    tick();
    {startFullReset, startClear1, startClear2, startReplay1, startReplay2} = 5'h00;
    tick();
    while (busy !== 1'b0 && i < 300)
    begin
      tick();
      i++;
    end
    check(i < 300, 1'b1);
    repeat (12) tick();
  endtask

  task automatic put(input logic two, input logic [35:0] base, input int n);
    for (int i = 0; i < n; i++)
    begin
      if (two) {fifo2Write, fifo2WriteData} = {1'b1, base + i};
      else {fifo1Write, fifo1WriteData} = {1'b1, base + i};
      tick();
    end
    {fifo1Write, fifo2Write} = 2'b00;
    tick();
  endtask

  task automatic get(input logic two, input logic [35:0] want);
    if (two) fifo2Read = 1'b1;
    else fifo1Read = 1'b1;
    tick();
    {fifo1Read, fifo2Read} = 2'b00;
    tick();
    check(two ? fifo2ReadData : fifo1ReadData, want);
  endtask

  task automatic mail(input logic two);
    {mail1Write, mail2Write} = {!two, two};
    tick();
    {mail1Write, mail2Write} = 2'b00;
    repeat (4) tick();
    check(two ? link.mail2_full_n : link.mail1_full_n, 1'b0);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    results();
  end

  initial
  begin
    {clk_sys, reset, mismatches, n_compared} = {2'b01, 64'h0};
    {startFullReset, startClear1, startClear2, startReplay1, startReplay2} = 5'h00;
    {fifo1Write, fifo1Read, fifo2Write, fifo2Read, mail1Write, mail2Write} = 6'h00;
    {fifo1WriteData, fifo2WriteData} = 72'h0;
    {cfgBigEndian, cfgFallThrough, cfgOffsetSelect} = 5'b1_0101;
    repeat (8) @(posedge clk_sys);
    #2 reset = 1'b0;
    tick();
    run(0);
    check(bigEndian, 1'b1);
    check(offsetMethod, 3'b101);
    check(fallThrough, 1'b0);
    check({fifo2EmptyOffset, fifo2FullOffset}, 26'h000_0000);
    check({link.fifo1_space_flag, link.fifo2_space_flag, deviceReady}, 3'b111);
    put(0, 36'h0_0000_00a0, 3);
    get(0, 36'h0_0000_00a0);
    get(0, 36'h0_0000_00a1);
    run(3);
    get(0, 36'h0_0000_00a0);
    mail(0);
    // moved config pins must not reach the device on a partial clear
    {cfgBigEndian, cfgOffsetSelect} = 4'b0_010;
    run(1);
    check({link.mail1_full_n, link.fifo1_data_flag}, 2'b10);
    check({link.fifo1_near_empty_n, link.fifo1_near_full_n}, 2'b01);
    check(link.fifo1_space_flag, 1'b1);
    check({bigEndian, offsetMethod, fallThrough}, 5'b1_1010);
    put(0, 36'h0_0000_00b0, 1);
    get(0, 36'h0_0000_00b0);
    put(1, 36'h0_0000_00c0, 2);
    get(1, 36'h0_0000_00c0);
    run(4);
    get(1, 36'h0_0000_00c0);
    mail(1);
    run(2);
    check({link.mail2_full_n, link.fifo2_data_flag, link.fifo2_space_flag}, 3'b101);
    check({link.fifo2_near_empty_n, link.fifo2_near_full_n}, 2'b01);
    put(0, 36'h0_0000_00d0, 1);
    mail(0);
    {cfgBigEndian, cfgFallThrough, cfgOffsetSelect} = 5'b0_1010;
    run(0);
    check({link.mail1_full_n, link.fifo1_data_flag}, 2'b10);
    check({bigEndian, offsetMethod}, 4'b0_010);
    check(fallThrough, 1'b1);
    results();
  end
endmodule
